// ---- logic/irlp_pkg.sv ----
// Shared constants and types for the IR activity power controller.
// Assumes a single 20 MHz system clock; all times are turned into cycles here.
package irlp_pkg;

  // System clock rate and derived per-unit cycle counts.
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;

  // Inactivity window before low power, in milliseconds and in cycles.
  localparam int unsigned INACT_MS      = 10000;
  localparam int unsigned INACT_CYCLES  = INACT_MS * CYC_PER_MS;

  // Fixed IR signalling rate and the cycles in one bit time.
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BAUD_CYCLES   = CLK_HZ / BAUD_RATE;

  // Fixed answer delay after a link-open frame, in microseconds and cycles.
  localparam int unsigned RESP_US       = 100;
  localparam int unsigned RESP_CYCLES   = RESP_US * CYC_PER_US;

  // Delivery stall that drops the link, in milliseconds and cycles.
  localparam int unsigned LINK_TO_MS    = 3000;
  localparam int unsigned LINK_TO_CYCLES = LINK_TO_MS * CYC_PER_MS;

  // Cycles spent initialising after reset before the disconnect state.
  localparam int unsigned INIT_CYCLES   = 16;

  // Frame and buffer sizing.
  localparam int unsigned PAYLOAD_MAX   = 64;
  localparam int unsigned CTRL_OVERHEAD = 4;
  localparam int unsigned DATA_MAX      = PAYLOAD_MAX - CTRL_OVERHEAD;
  localparam int unsigned PROTO_BYTES   = 8;
  localparam int unsigned CTS_LEVEL     = 59;

  // Widths of the timer and length fields.
  localparam int unsigned TMR_W         = 28;
  localparam int unsigned LEN_W         = 7;

  // Reset values of the pin-facing outputs.
  localparam logic        HACT_OE_N_RST = 1'b1;
  localparam logic        OSC_RUN_RST   = 1'b1;

  // Protocol handler power states.
  typedef enum logic [1:0] {
    ST_INIT,
    ST_DISCONNECT,
    ST_LINKED,
    ST_LOW_POWER
  } irlp_state_t;

  // Description of one outgoing frame.
  typedef struct packed {
    logic [LEN_W-1:0] data_len;
    logic [LEN_W-1:0] payload_len;
    logic [LEN_W-1:0] wire_len;
  } irlp_tx_frame_t;

  // Description of one incoming frame as seen by the host side.
  typedef struct packed {
    logic [LEN_W-1:0] data_len;
    logic [LEN_W-1:0] wire_len;
  } irlp_rx_frame_t;

endpackage

// ---- logic/irlp_timer.sv ----
// Reloadable down-counting timer with a one-cycle done pulse.
// Assumes start, stop and load come from logic on the same clock.
`timescale 1ns/1ns
module irlp_timer #(
  parameter int unsigned W = 28
) (
  // Clock, reset and enable.
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         clk_en_i,
  // Control.
  input  wire logic         start_i,
  input  wire logic         stop_i,
  input  wire logic [W-1:0] load_i,
  // Status.
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] count;

  // A start reloads even while running, so a restart never needs a stop first.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      count  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        count  <= load_i;
        busy_o <= 1'b1;
      end else if (stop_i) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        if (count <= W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end

endmodule

// ---- logic/irlp_power_ctrl.sv ----
// Activity-driven power controller and frame sizing for an IR secondary device.
// Assumes the protocol handler signals link events as one-cycle pulses on sys_clk_i,
// and that detector, reference, handler line and host RTS are asynchronous pins.
//
// Operation
// [RULE_01] Link closure returns the handler to the disconnect state.
// [RULE_02] Ten seconds without IR activity in disconnect enters low power.
// [RULE_03] Low power stops the oscillator and pulls handler-active low.
// [RULE_04] A detector crossing its reference wakes the device from low power.
// [RULE_05] Reset leaves low power; ten idle seconds after init return there.
// [RULE_06] Handler-active is high while working or waiting, low in low power.
// [RULE_07] Handler-active is open collector: only pulled low, pull-up gives high.
// [RULE_08] IR rate is fixed at 9600 baud, never negotiated.
// [RULE_09] A 64-byte payload has 4 overhead bytes, so at most 60 data bytes.
// [RULE_10] Every packet carries 8 extra serial-emulation protocol bytes.
// [RULE_11] Host receive buffer holds 60 bytes; CTS rises after byte 59.
// [RULE_12] The answer to a link-open frame follows a fixed internal delay.
// [RULE_13] Outgoing data frames are filled with as many bytes as allowed.
// [RULE_14] Host must hold RTS low for delivery, else the link times out.
// [RULE_15] IR activity in disconnect restarts the ten-second inactivity timer.
`timescale 1ns/1ns
module irlp_power_ctrl #(
  parameter int unsigned INACT_CYC   = irlp_pkg::INACT_CYCLES,
  parameter int unsigned LINK_TO_CYC = irlp_pkg::LINK_TO_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic                     sys_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     clk_en_i,
  // Detector pins.
  input  wire logic                     ir_detect_in_i,
  input  wire logic                     ir_detect_ref_i,
  // Handler-active open-collector pin.
  input  wire logic                     handler_active_in_i,
  output logic                          handler_active_out_o,
  output logic                          handler_active_oe_n_o,
  output logic                          handler_line_o,
  // Protocol handler events.
  input  wire logic                     link_open_i,
  input  wire logic                     link_closed_i,
  output logic                          resp_send_o,
  output logic                          link_drop_o,
  output logic                          osc_run_o,
  output logic                          low_power_o,
  // Host UART receive side and outgoing frames.
  input  wire logic                     uart_rx_byte_i,
  input  wire logic                     tx_slot_i,
  output logic                          cts_o,
  output logic                          uart_overrun_o,
  output logic                          tx_frame_valid_o,
  output irlp_pkg::irlp_tx_frame_t      tx_frame_o,
  // Incoming frames and delivery to the host.
  input  wire logic                     rx_frame_i,
  input  wire logic [irlp_pkg::LEN_W-1:0] rx_payload_len_i,
  input  wire logic                     host_rts_n_i,
  output logic                          rx_byte_o,
  output irlp_pkg::irlp_rx_frame_t      rx_frame_o,
  output logic                          baud_tick_o
);

  localparam int unsigned TW = irlp_pkg::TMR_W;
  localparam int unsigned LW = irlp_pkg::LEN_W;
  localparam int unsigned BW = 12;

  irlp_pkg::irlp_state_t state;
  irlp_pkg::irlp_state_t next_state;

  logic [1:0]    det_sync;
  logic [1:0]    ref_sync;
  logic [1:0]    line_sync;
  logic [1:0]    rts_sync;
  logic          above;
  logic          above_q;
  logic          activity;
  logic [4:0]    init_cnt;
  logic          init_done;
  logic          inact_start;
  logic          inact_done;
  logic          resp_done;
  logic          to_cond;
  logic          to_busy;
  logic          to_done;
  logic [BW-1:0] baud_cnt;
  logic          baud_tick;
  logic [LW-1:0] host_fill;
  logic [LW-1:0] rx_left;
  logic          take;
  logic          rx_take;

  // Every asynchronous pin crosses two flops; only the second one is read.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      det_sync  <= 2'h0;
      ref_sync  <= 2'h0;
      line_sync <= 2'h0;
      rts_sync  <= 2'h3;
    end else if (clk_en_i) begin
      det_sync  <= {det_sync[0], ir_detect_in_i};
      ref_sync  <= {ref_sync[0], ir_detect_ref_i};
      line_sync <= {line_sync[0], handler_active_in_i};
      rts_sync  <= {rts_sync[0], host_rts_n_i};
    end
  end

  // Activity is any change of the detector-above-reference comparison.
  assign above    = det_sync[1] & ~ref_sync[1];
  assign activity = above ^ above_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      above_q <= 1'b0;
    end else if (clk_en_i) begin
      above_q <= above;
    end
  end

  // Short initialisation after reset before the idle watch begins.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      init_cnt <= 5'h00;
    end else if (clk_en_i && state == irlp_pkg::ST_INIT && !init_done) begin
      init_cnt <= init_cnt + 5'h01;
    end
  end

  assign init_done = (init_cnt >= 5'(irlp_pkg::INIT_CYCLES - 1));

  // Next power state; closure and timeout both fall back to disconnect.
  always_comb begin
    next_state = state;
    unique case (state)
      irlp_pkg::ST_INIT: begin
        if (init_done) begin
          next_state = irlp_pkg::ST_DISCONNECT;
        end
      end
      irlp_pkg::ST_DISCONNECT: begin
        if (link_open_i) begin
          next_state = irlp_pkg::ST_LINKED;
        end else if (inact_done && !activity) begin
          next_state = irlp_pkg::ST_LOW_POWER; // see [RULE_02]
        end
      end
      irlp_pkg::ST_LINKED: begin
        if (link_closed_i || to_done) begin
          next_state = irlp_pkg::ST_DISCONNECT; // see [RULE_01] see [RULE_14]
        end
      end
      irlp_pkg::ST_LOW_POWER: begin
        if (activity) begin
          next_state = irlp_pkg::ST_DISCONNECT; // see [RULE_04]
        end
      end
    endcase
  end

  // Reset always lands in init, which is how reset leaves low power.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= irlp_pkg::ST_INIT; // see [RULE_05]
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  // The idle timer restarts on entry to disconnect and on every activity edge while the state stays in disconnect.
  assign inact_start = (next_state == irlp_pkg::ST_DISCONNECT) &&
                       (state != irlp_pkg::ST_DISCONNECT || activity); // see [RULE_15]

  irlp_timer #(
    .W (TW)
  ) u_inact (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .start_i   (inact_start),
    .stop_i    (next_state != irlp_pkg::ST_DISCONNECT),
    .load_i    (TW'(INACT_CYC)), // see [RULE_05]
    .busy_o    (),
    .done_o    (inact_done)
  );

  // The answer delay is a fixed constant; the host has no say in it.
  irlp_timer #(
    .W (TW)
  ) u_resp (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .start_i   (state == irlp_pkg::ST_DISCONNECT && link_open_i),
    .stop_i    (next_state != irlp_pkg::ST_LINKED),
    .load_i    (TW'(irlp_pkg::RESP_CYCLES)), // see [RULE_12]
    .busy_o    (),
    .done_o    (resp_done)
  );

  // Data waiting while the host holds RTS high runs the link timeout.
  assign to_cond = (state == irlp_pkg::ST_LINKED) && (rx_left != '0) && rts_sync[1];

  irlp_timer #(
    .W (TW)
  ) u_link_to (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .start_i   (to_cond && !to_busy && !to_done),
    .stop_i    (!to_cond),
    .load_i    (TW'(LINK_TO_CYC)), // see [RULE_14]
    .busy_o    (to_busy),
    .done_o    (to_done)
  );

  // Power pins; the oscillator request drops and the pin is pulled only in low power.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      osc_run_o             <= irlp_pkg::OSC_RUN_RST;
      handler_active_oe_n_o <= irlp_pkg::HACT_OE_N_RST;
      handler_active_out_o  <= 1'b0;
      low_power_o           <= 1'b0;
      handler_line_o        <= 1'b0;
    end else if (clk_en_i) begin
      osc_run_o             <= (next_state != irlp_pkg::ST_LOW_POWER); // see [RULE_03]
      handler_active_oe_n_o <= (next_state != irlp_pkg::ST_LOW_POWER); // see [RULE_06]
      handler_active_out_o  <= 1'b0; // see [RULE_07]
      low_power_o           <= (next_state == irlp_pkg::ST_LOW_POWER);
      handler_line_o        <= line_sync[1];
    end
  end

  // Event pulses toward the protocol handler.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      resp_send_o <= 1'b0;
      link_drop_o <= 1'b0;
    end else if (clk_en_i) begin
      resp_send_o <= resp_done;
      link_drop_o <= to_done && state == irlp_pkg::ST_LINKED;
    end
  end

  // Fixed bit-time tick; there is no rate register to change it.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      baud_cnt    <= '0;
      baud_tick_o <= 1'b0;
    end else if (clk_en_i) begin
      baud_tick_o <= baud_tick;
      if (baud_tick) begin
        baud_cnt <= '0;
      end else begin
        baud_cnt <= baud_cnt + BW'(1); // see [RULE_08]
      end
    end
  end

  assign baud_tick = (baud_cnt == BW'(irlp_pkg::BAUD_CYCLES - 1));

  // Host buffer fill; a frame takes everything queued, which is at most 60.
  assign take = tx_slot_i && (state == irlp_pkg::ST_LINKED) && (host_fill != '0);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      host_fill      <= '0;
      cts_o          <= 1'b0;
      uart_overrun_o <= 1'b0;
    end else if (clk_en_i) begin
      uart_overrun_o <= 1'b0;
      if (take) begin
        host_fill <= LW'(uart_rx_byte_i);
        cts_o     <= 1'b0;
      end else if (uart_rx_byte_i) begin
        if (host_fill < LW'(irlp_pkg::DATA_MAX)) begin
          host_fill <= host_fill + LW'(1);
        end else begin
          uart_overrun_o <= 1'b1;
        end
        cts_o <= (host_fill >= LW'(irlp_pkg::CTS_LEVEL - 1)); // see [RULE_11]
      end
    end
  end

  // Outgoing frame: data, payload with control bytes, and total with protocol bytes.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_frame_valid_o <= 1'b0;
      tx_frame_o       <= '0;
    end else if (clk_en_i) begin
      tx_frame_valid_o <= take;
      if (take) begin
        tx_frame_o.data_len    <= host_fill; // see [RULE_13]
        tx_frame_o.payload_len <= host_fill + LW'(irlp_pkg::CTRL_OVERHEAD); // see [RULE_09]
        tx_frame_o.wire_len    <= host_fill + LW'(irlp_pkg::PROTO_BYTES); // see [RULE_10]
      end
    end
  end

  // Incoming frames hand their data bytes to the host one per bit time.
  assign rx_take = rx_frame_i && (state == irlp_pkg::ST_LINKED) && (rx_left == '0);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_left    <= '0;
      rx_byte_o  <= 1'b0;
      rx_frame_o <= '0;
    end else if (clk_en_i) begin
      rx_byte_o <= 1'b0;
      if (next_state != irlp_pkg::ST_LINKED) begin
        rx_left <= '0;
      end else if (rx_take) begin
        if (rx_payload_len_i <= LW'(irlp_pkg::CTRL_OVERHEAD)) begin
          rx_left <= '0;
        end else if (rx_payload_len_i >= LW'(irlp_pkg::PAYLOAD_MAX)) begin
          rx_left <= LW'(irlp_pkg::DATA_MAX); // see [RULE_09]
        end else begin
          rx_left <= rx_payload_len_i - LW'(irlp_pkg::CTRL_OVERHEAD);
        end
        rx_frame_o.wire_len <= rx_payload_len_i + LW'(irlp_pkg::PROTO_BYTES - 4); // see [RULE_10]
      end else if (baud_tick && !rts_sync[1] && rx_left != '0) begin
        rx_left   <= rx_left - LW'(1); // see [RULE_14]
        rx_byte_o <= 1'b1;
      end
      if (rx_take) begin
        rx_frame_o.data_len <= (rx_payload_len_i >= LW'(irlp_pkg::PAYLOAD_MAX)) ?
                               LW'(irlp_pkg::DATA_MAX) :
                               (rx_payload_len_i > LW'(irlp_pkg::CTRL_OVERHEAD)) ?
                               rx_payload_len_i - LW'(irlp_pkg::CTRL_OVERHEAD) : '0;
      end
    end
  end

endmodule

// ---- bench/irlp_monitor.sv ----
// Port checker for the IR activity power controller, bound to its top module.
// Assumes one clock domain with a synchronous, active-high reset.
`timescale 1ns/1ns
module irlp_monitor #(
  parameter int unsigned INACT_CYC   = 200,
  parameter int unsigned LINK_TO_CYC = 100
) (
  // Clock and reset.
  input wire logic               sys_clk_i,
  input wire logic               sys_rst_i,
  // Inputs that count as activity or stall.
  input wire logic               ir_detect_in_i,
  input wire logic               ir_detect_ref_i,
  input wire logic               link_open_i,
  input wire logic               link_closed_i,
  input wire logic               rx_frame_i,
  input wire logic               host_rts_n_i,
  // Outputs under watch.
  input wire logic               handler_active_out_o,
  input wire logic               handler_active_oe_n_o,
  input wire logic               resp_send_o,
  input wire logic               link_drop_o,
  input wire logic               osc_run_o,
  input wire logic               low_power_o,
  input wire logic               cts_o,
  input wire logic               uart_overrun_o,
  input wire logic               tx_frame_valid_o,
  input irlp_pkg::irlp_tx_frame_t tx_frame_o,
  input wire logic               baud_tick_o
);
  int unsigned idle_cnt;
  int unsigned open_cnt;
  int unsigned baud_cnt;
  int unsigned rts_hi;
  logic [1:0]  det_q;
  logic        baud_seen;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Cycles since any sign of activity; the design sees activity later, never sooner.
  always_ff @(posedge sys_clk_i) begin
    det_q <= {ir_detect_ref_i, ir_detect_in_i};
    if (sys_rst_i || det_q != {ir_detect_ref_i, ir_detect_in_i} || link_open_i || link_closed_i ||
        rx_frame_i)
      idle_cnt <= 0;
    else if (idle_cnt < 32'h7FFF_FFFF)
      idle_cnt <= idle_cnt + 1;
  end

  // Age of the last link-open request; starts huge so a stray answer fails.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i)
      open_cnt <= 32'h7FFF_FFFF;
    else if (link_open_i)
      open_cnt <= 0;
    else if (open_cnt < 32'h7FFF_FFFF)
      open_cnt <= open_cnt + 1;
  end

  // Bit-time spacing; the first tick after reset or low power is not judged.
  always_ff @(posedge sys_clk_i) begin
    baud_cnt <= (sys_rst_i || baud_tick_o) ? 0 : baud_cnt + 1;
    baud_seen <= (sys_rst_i || low_power_o) ? 1'b0 : (baud_tick_o | baud_seen);
  end

  // Consecutive cycles with the host not ready.
  always_ff @(posedge sys_clk_i) begin
    rts_hi <= (sys_rst_i || !host_rts_n_i) ? 0 : rts_hi + 1;
  end

  a_lp_pins_parked: assert property ($rose(low_power_o) |-> ##[0:1] (!osc_run_o && !handler_active_oe_n_o))
    else $error("oscillator or handler line not parked in low power");
  a_hact_pull_only: assert property (handler_active_out_o == 1'b0)
    else $error("handler line driven high");
  a_wake_on_cross: assert property ((low_power_o && !ir_detect_ref_i && $changed(ir_detect_in_i)) |-> ##[1:8] !low_power_o)
    else $error("no wake after detector crossing");
  a_idle_window: assert property ($rose(low_power_o) |-> idle_cnt >= INACT_CYC)
    else $error("low power entered before the idle window");
  a_tx_sizes: assert property (tx_frame_valid_o |-> (tx_frame_o.payload_len == tx_frame_o.data_len + 4 && tx_frame_o.wire_len == tx_frame_o.data_len + 8 && tx_frame_o.data_len inside {[1:60]}))
    else $error("frame sizes inconsistent");
  a_cts_overrun: assert property (uart_overrun_o |-> cts_o)
    else $error("overrun without clear-to-send high");
  a_resp_delay: assert property (resp_send_o |-> open_cnt inside {[1999:2004]})
    else $error("link-open answer delay wrong");
  a_baud_period: assert property ((baud_tick_o && baud_seen) |-> baud_cnt == irlp_pkg::BAUD_CYCLES - 1)
    else $error("bit time spacing wrong");
  a_drop_stall: assert property (link_drop_o |-> rts_hi >= LINK_TO_CYC)
    else $error("link dropped before the stall limit");

  c_low_power: cover property ($rose(low_power_o));
  c_full_frame: cover property (tx_frame_valid_o && tx_frame_o.data_len == 7'h3C);
  c_drop: cover property (link_drop_o);
endmodule

bind irlp_power_ctrl irlp_monitor #(.INACT_CYC(INACT_CYC), .LINK_TO_CYC(LINK_TO_CYC)) mon_u (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ir_detect_in_i(ir_detect_in_i),
  .ir_detect_ref_i(ir_detect_ref_i), .link_open_i(link_open_i), .link_closed_i(link_closed_i),
  .rx_frame_i(rx_frame_i), .host_rts_n_i(host_rts_n_i),
  .handler_active_out_o(handler_active_out_o), .handler_active_oe_n_o(handler_active_oe_n_o),
  .resp_send_o(resp_send_o), .link_drop_o(link_drop_o), .osc_run_o(osc_run_o),
  .low_power_o(low_power_o), .cts_o(cts_o), .uart_overrun_o(uart_overrun_o),
  .tx_frame_valid_o(tx_frame_valid_o), .tx_frame_o(tx_frame_o), .baud_tick_o(baud_tick_o));

// ---- bench/irlp_host_model.sv ----
// Host-side partner: the pulled-up handler-active wire and the host ready pin.
// Assumes the bench raises stall_i when the host should refuse delivery.
`timescale 1ns/1ns
module irlp_host_model (
  // Clock.
  input  wire logic sys_clk_i,
  // Bench control.
  input  wire logic stall_i,
  // Device pins.
  input  wire logic handler_active_out_i,
  input  wire logic handler_active_oe_n_i,
  output logic      handler_wire_o,
  output logic      host_rts_n_o
);
  // The pull-up gives the high level whenever the device lets go of the line.
  assign handler_wire_o = handler_active_oe_n_i ? 1'b1 : handler_active_out_i;

  // Ready is low unless stalled, moved on the falling edge away from sampling.
  initial host_rts_n_o = 1'b0;
  always @(negedge sys_clk_i) host_rts_n_o <= stall_i;
endmodule

// ---- bench/irlp_power_ctrl_tb_top.sv ----
// Self-checking bench for the IR activity power controller.
// Assumes short timer parameters and the monitor bound from its own file.
`timescale 1ns/1ns
module irlp_power_ctrl_tb_top;
  localparam int unsigned INACT = 200;
  localparam int unsigned LTO   = 100;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, det = 1'b0, ref_v = 1'b0;
  logic l_open = 1'b0, l_close = 1'b0, byte_in = 1'b0, slot = 1'b0, rx_in = 1'b0, stall = 1'b0;
  logic [6:0] rx_len = 7'h00;
  logic [15:0] rnd = 16'hAB08;
  logic oc_out, oe_n, hline, wire_lvl, rts_n, resp, drop, osc, lp, cts, ovr, txv, rxb, tick;
  irlp_pkg::irlp_tx_frame_t txf;
  irlp_pkg::irlp_rx_frame_t rxf;
  int n_fail = 0, n_checks = 0, n_ovr = 0, n_rxb = 0;

  // Clock at 20 MHz.
  always #25 sys_clk_i = ~sys_clk_i;

  // Pulse counters, so one-cycle outputs are never missed.
  always @(posedge sys_clk_i) begin
    n_ovr += ovr;
    n_rxb += rxb;
  end

  irlp_power_ctrl #(.INACT_CYC(INACT), .LINK_TO_CYC(LTO)) dut_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .ir_detect_in_i(det), .ir_detect_ref_i(ref_v), .handler_active_in_i(wire_lvl),
    .handler_active_out_o(oc_out), .handler_active_oe_n_o(oe_n), .handler_line_o(hline),
    .link_open_i(l_open), .link_closed_i(l_close), .resp_send_o(resp), .link_drop_o(drop),
    .osc_run_o(osc), .low_power_o(lp), .uart_rx_byte_i(byte_in), .tx_slot_i(slot),
    .cts_o(cts), .uart_overrun_o(ovr), .tx_frame_valid_o(txv), .tx_frame_o(txf),
    .rx_frame_i(rx_in), .rx_payload_len_i(rx_len), .host_rts_n_i(rts_n), .rx_byte_o(rxb),
    .rx_frame_o(rxf), .baud_tick_o(tick));

  irlp_host_model host_u (.sys_clk_i(sys_clk_i), .stall_i(stall), .handler_active_out_i(oc_out),
    .handler_active_oe_n_i(oe_n), .handler_wire_o(wire_lvl), .host_rts_n_o(rts_n));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Data bytes left in a frame once the 4 control bytes are removed, at most 60.
  function automatic int rx_data(input int len);
    return (len <= 4) ? 0 : ((len - 4 > 60) ? 60 : len - 4);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // One-cycle strobe followed by an idle cycle, so calls never collide.
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk_i);
    s = 1'b0;
    @(negedge sys_clk_i);
  endtask

  // Back-to-back host bytes, then two quiet cycles for the flag to settle.
  task automatic send(input int n);
    byte_in = 1'b1;
    cyc(n);
    byte_in = 1'b0;
    cyc(2);
  endtask

  task automatic wait_lp(input logic want, input int lim);
    for (int t = 0; t < lim && lp !== want; t++) @(negedge sys_clk_i);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about fifty thousand cycles.
  initial begin
    #5000000;
    n_fail++;
    end_of_test();
  end

  // Main sequence: idle and wake, link traffic, stall drop, close, reset.
  initial begin
    int n, t;
    cyc(16);
    sys_rst_i = 1'b0;
    cyc(INACT / 2);
    chk("awake early", 0, lp);
    chk("line released", 1, hline);
    clk_en_i = 1'b0; // A frozen idle timer must not expire however long the enable stays low.
    cyc(INACT);
    chk("frozen awake", 0, lp);
    clk_en_i = 1'b1;
    wait_lp(1'b1, INACT);
    cyc(4);
    chk("low power", 1, lp);
    chk("osc stopped", 0, osc);
    chk("line pulled", 0, hline);
    det = ~det;
    wait_lp(1'b0, 10);
    cyc(2);
    chk("woken", 1, oe_n);
    repeat (4) begin
      cyc(INACT * 3 / 4);
      det = ~det;
    end
    chk("kept awake", 0, lp);
    l_open = 1'b1;
    @(negedge sys_clk_i);
    l_open = 1'b0;
    for (t = 1; t < 2100 && resp !== 1'b1; t++) @(negedge sys_clk_i);
    chk("answer delay", 1, t >= 1999 && t <= 2004);
    chk("linked awake", 0, lp);
    // A 58/61 corner first, then random fills.
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      n = (k == 0) ? 61 : rnd % 60 + 1;
      if (k == 0) begin
        send(58);
        chk("cts at 58", 0, cts);
        send(3);
      end else begin
        send(n);
      end
      chk("cts", n >= 59, cts);
      slot = 1'b1;
      @(negedge sys_clk_i);
      slot = 1'b0;
      chk("tx valid", 1, txv);
      chk("tx frame", {7'(rx_data(n + 4)), 7'(rx_data(n + 4) + 4), 7'(rx_data(n + 4) + 8)}, txf);
      cyc(1);
    end
    chk("overrun", 1, n_ovr);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      rx_len = (k == 0) ? 7'h04 : 7'(rnd % 6 + 5);
      n_rxb = 0;
      pulse(rx_in);
      chk("rx frame", {7'(rx_data(rx_len)), rx_len + 7'h04}, rxf);
      cyc(2083 * 7);
      chk("rx bytes", rx_data(rx_len), n_rxb);
    end
    stall = 1'b1;
    rx_len = 7'h46;
    pulse(rx_in);
    chk("rx clamp", {7'(rx_data(rx_len)), rx_len + 7'h04}, rxf);
    for (t = 0; t < LTO + 20 && drop !== 1'b1; t++) @(negedge sys_clk_i);
    chk("link dropped", 1, drop);
    stall = 1'b0;
    wait_lp(1'b1, INACT + 20);
    chk("idle after drop", 1, lp);
    ref_v = 1'b1; // The detector is high here, so a rising reference is a crossing.
    wait_lp(1'b0, 10);
    chk("ref wake", 0, lp);
    pulse(l_open);
    cyc(10);
    pulse(l_close);
    wait_lp(1'b1, INACT + 20);
    chk("idle after close", 1, lp);
    sys_rst_i = 1'b1;
    cyc(2);
    sys_rst_i = 1'b0;
    cyc(2);
    chk("reset wakes", 0, lp);
    chk("reset osc", 1, osc);
    wait_lp(1'b1, INACT + 40);
    chk("idle after reset", 1, lp);
    end_of_test();
  end
endmodule
